// [ums_pkg.sv]
// Shared constants of the UART line and modem status block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package ums_pkg;

	// Bus geometry
	localparam int unsigned UMS_ADR_W = 5;
	localparam int unsigned UMS_DAT_W = 32;
	localparam int unsigned UMS_SEL_W = 4;
	localparam int unsigned UMS_REG_W = 8;

	// Register byte offsets
	localparam logic [4:0] UMS_OFS_RX_DATA    = 5'h00;
	localparam logic [4:0] UMS_OFS_LINE_STAT  = 5'h04;
	localparam logic [4:0] UMS_OFS_MODEM_STAT = 5'h08;
	localparam logic [4:0] UMS_OFS_MODEM_CTRL = 5'h0C;
	localparam logic [4:0] UMS_OFS_FIFO_CTRL  = 5'h10;
	localparam logic [4:0] UMS_OFS_IRQ_STAT   = 5'h14;
	localparam logic [4:0] UMS_OFS_IRQ_CLEAR  = 5'h18;
	localparam logic [4:0] UMS_OFS_IRQ_ENABLE = 5'h1C;

	// Line status fields
	localparam int unsigned UMS_LS_DATA_READY = 0;
	localparam int unsigned UMS_LS_OVERRUN    = 1;
	localparam int unsigned UMS_LS_PARITY     = 2;
	localparam logic [7:0]  UMS_LS_TX_IDLE    = 8'h60;
	localparam logic [7:0]  UMS_LS_RESET      = 8'h60;

	// Modem signal index, shared by live and change fields
	localparam int unsigned UMS_MS_CTS   = 0;
	localparam int unsigned UMS_MS_DSR   = 1;
	localparam int unsigned UMS_MS_RI    = 2;
	localparam int unsigned UMS_MS_CD    = 3;
	localparam int unsigned UMS_MS_N     = 4;
	localparam int unsigned UMS_MS_LIVE0 = 4;

	// Modem control fields
	localparam int unsigned UMS_MC_DTR  = 0;
	localparam int unsigned UMS_MC_RTS  = 1;
	localparam int unsigned UMS_MC_OUT1 = 2;
	localparam int unsigned UMS_MC_OUT2 = 3;
	localparam int unsigned UMS_MC_LOOP = 4;
	localparam logic [7:0]  UMS_MC_RESET = 8'h00;

	// FIFO control and interrupt fields
	localparam int unsigned UMS_FC_ENABLE   = 0;
	localparam int unsigned UMS_IRQ_RX      = 0;
	localparam int unsigned UMS_IRQ_OVERRUN = 1;
	localparam int unsigned UMS_IRQ_PARITY  = 2;
	localparam int unsigned UMS_IRQ_MODEM   = 3;
	localparam int unsigned UMS_IRQ_N       = 4;

	// Character entry: parity flag above the data byte
	localparam int unsigned UMS_CHAR_W  = 9;
	localparam int unsigned UMS_CHAR_PE = 8;

	// Pin synchroniser depth
	localparam int unsigned UMS_SYNC_STAGES = 3;

endpackage : ums_pkg

// [ums_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; the filtered level moves only when
// stages two and three agree, so a single metastable sample is ignored.
module ums_sync #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out
);
	import ums_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] filt;
	} ums_sync_t;

	ums_sync_t sync_reg;
	ums_sync_t sync_next;

	// Shift chain; first stage feeds only the second
	always_comb begin
		sync_next    = sync_reg;
		sync_next.s1 = async_in;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (sync_reg.s2[i] == sync_reg.s3[i]) begin
				sync_next.filt[i] = sync_reg.s3[i]; // R18
			end
		end
		// Pins are stable during reset: fill the whole chain at once so
		// a short reset leaves no unknown level and release sees no change
		if (sys_rst) begin
			sync_next.s2   = async_in;
			sync_next.s3   = async_in;
			sync_next.filt = async_in;
		end
	end

	always_ff @(posedge clock) begin
		sync_reg <= sync_next;
	end

	assign level_out = sync_reg.filt;

endmodule : ums_sync

// [ums_rx_fifo.sv]
// Receive character queue with run-time fill limit.
// Assumes one push and one pop port; a limit of one gives holding
// register behaviour when queueing is off.
module ums_rx_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 16,
	localparam int unsigned AW   = $clog2(DEPTH),
	localparam int unsigned CW   = $clog2(DEPTH + 1)
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             flush,
	input  wire logic [CW-1:0]    limit,
	input  wire logic             push_valid,
	input  wire logic [WIDTH-1:0] push_data,
	output logic                  push_ready,
	input  wire logic             pop,
	output logic [WIDTH-1:0]      head_data,
	output logic                  head_valid,
	output logic [CW-1:0]         level
);
	import ums_pkg::*;

	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [CW-1:0]               count;
	} ums_fifo_t;

	ums_fifo_t fifo_reg;
	ums_fifo_t fifo_next;
	logic      do_push;
	logic      do_pop;

	// Full is judged before a same-cycle pop, which keeps timing short
	assign push_ready = (fifo_reg.count < limit);
	assign head_valid = (fifo_reg.count != '0);
	assign head_data  = fifo_reg.mem[fifo_reg.rd];
	assign level      = fifo_reg.count;
	assign do_push    = push_valid & push_ready;
	assign do_pop     = pop & head_valid;

	// Pointer and count update
	always_comb begin
		fifo_next = fifo_reg;
		if (do_push) begin
			fifo_next.mem[fifo_reg.wr] = push_data;
			fifo_next.wr = (fifo_reg.wr == LAST) ? '0 : AW'(fifo_reg.wr + 1'b1);
		end
		if (do_pop) begin
			fifo_next.rd = (fifo_reg.rd == LAST) ? '0 : AW'(fifo_reg.rd + 1'b1);
		end
		if (do_push && !do_pop) begin
			fifo_next.count = CW'(fifo_reg.count + 1'b1);
		end else if (do_pop && !do_push) begin
			fifo_next.count = CW'(fifo_reg.count - 1'b1);
		end
		if (sys_rst || flush) begin
			fifo_next.rd    = '0;
			fifo_next.wr    = '0;
			fifo_next.count = '0;
		end
	end

	always_ff @(posedge clock) begin
		fifo_reg <= fifo_next;
	end

endmodule : ums_rx_fifo

// [ums_status.sv]
// Line and modem status logic of one UART channel, Wishbone slave.
// Assumes a receive shifter that pulses rx_char_valid per character
// and active-low modem pins that are asynchronous to clock.
//
// What this block does
// R1 - Line status bit 2 shows a parity error, zero when none present.
// R2 - In FIFO mode parity flag belongs to the character at FIFO head.
// R3 - Line status bit 1 sets when a character completes with FIFO full.
// R4 - On overrun the new character overwrites the receive shift register.
// R5 - On overrun the shift register character is not pushed into FIFO.
// R6 - Line status bit 0 is high while any received character is held.
// R7 - Modem status bits 3:0 are four change indicators of modem inputs.
// R8 - Any host read of modem status clears all four change bits; here a change in the cycle of the read stays set.
// R9 - Modem status bit 7 is inverted carrier detect, or control bit 3.
// R10 - Modem status bit 6 is inverted ring indicator, or control bit 2.
// R11 - Modem status bit 5 is inverted data set ready, or control bit 0.
// R12 - Modem status bit 4 is inverted clear to send, or control bit 1.
// R13 - Bits 3, 1, 0 set on any change of carrier, set ready, send.
// R14 - Bit 2 sets only when the ring pin rises from 0 to 1.
// R15 - Modem interrupt condition is raised while any change bit is one.
// R16 - Reset clears line status bit 7, sets bits 6:5, clears bits 4:0.
// R17 - Reset clears change bits; live bits keep following the inputs.
// R18 - Modem inputs are synchronised before change detection.
//
// Chosen here: the placing of the registers and the Wishbone register port.
module ums_status #(
	parameter int unsigned RX_DEPTH = 16,
	localparam int unsigned CW      = $clog2(RX_DEPTH + 1)
) (
	input  wire logic                     clock,
	input  wire logic                     sys_rst,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [ums_pkg::UMS_ADR_W-1:0] wb_adr_i,
	input  wire logic [ums_pkg::UMS_SEL_W-1:0] wb_sel_i,
	input  wire logic [ums_pkg::UMS_DAT_W-1:0] wb_dat_i,
	output logic      [ums_pkg::UMS_DAT_W-1:0] wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     rx_char_valid,
	input  wire logic [7:0]               rx_char_data,
	input  wire logic                     rx_char_perr,
	output logic      [7:0]               rx_shift_q,
	input  wire logic                     cts_n,
	input  wire logic                     dsr_n,
	input  wire logic                     ri_n,
	input  wire logic                     cd_n,
	output logic      [7:0]               modem_ctrl_q,
	output logic                          modem_irq,
	output logic                          irq
);
	import ums_pkg::*;

	typedef struct packed {
		logic                 ack;
		logic [UMS_DAT_W-1:0] dat;
		logic [UMS_REG_W-1:0] mc;
		logic                 fifo_en;
		logic [UMS_IRQ_N-1:0] irq_stat;
		logic [UMS_IRQ_N-1:0] irq_en;
		logic                 irq;
		logic                 overrun;
		logic [7:0]           shift;
		logic [UMS_MS_N-1:0]  delta;
		logic [UMS_MS_N-1:0]  prev;
	} ums_state_t;

	ums_state_t st_reg;
	ums_state_t st_next;

	logic [UMS_MS_N-1:0]   pin_level;
	logic [UMS_MS_N-1:0]   live;
	logic [UMS_MS_N-1:0]   loop_src;
	logic [UMS_MS_N-1:0]   delta_set;
	logic [7:0]            ls_val;
	logic [7:0]            ms_val;
	logic [UMS_CHAR_W-1:0] head;
	logic                  head_valid;
	logic                  push_ready;
	logic [CW-1:0]         level;
	logic [CW-1:0]         limit;
	logic                  req;
	logic                  rd_req;
	logic                  wr_req;
	logic                  rd_rx;
	logic                  rd_ms;
	logic                  rd_ls;
	logic                  flush;
	logic                  ovr_ev;
	logic [UMS_IRQ_N-1:0]  irq_ev;

	// Modem pins cross into the clock domain
	ums_sync #(
		.WIDTH (UMS_MS_N)
	) u_sync (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.async_in  ({cd_n, ri_n, dsr_n, cts_n}),
		.level_out (pin_level)
	);

	// Queueing off means a single holding register
	assign limit = st_reg.fifo_en ? CW'(RX_DEPTH) : CW'(1);

	ums_rx_fifo #(
		.WIDTH (UMS_CHAR_W),
		.DEPTH (RX_DEPTH)
	) u_fifo (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.flush      (flush),
		.limit      (limit),
		.push_valid (rx_char_valid), // R5
		.push_data  ({rx_char_perr, rx_char_data}),
		.push_ready (push_ready),
		.pop        (rd_rx),
		.head_data  (head),
		.head_valid (head_valid),
		.level      (level)
	);

	// Bus decode; one access per ack, effects at the taking edge
	assign req    = wb_cyc_i & wb_stb_i & ~st_reg.ack;
	assign rd_req = req & ~wb_we_i;
	assign wr_req = req & wb_we_i & wb_sel_i[0];
	assign rd_rx  = rd_req & (wb_adr_i == UMS_OFS_RX_DATA);
	assign rd_ls  = rd_req & (wb_adr_i == UMS_OFS_LINE_STAT);
	assign rd_ms  = rd_req & (wb_adr_i == UMS_OFS_MODEM_STAT);
	assign flush  = wr_req & (wb_adr_i == UMS_OFS_FIFO_CTRL) &
		(wb_dat_i[UMS_FC_ENABLE] != st_reg.fifo_en);
	assign ovr_ev = rx_char_valid & ~push_ready; // R3

	// Loopback replaces pins with control outputs
	assign loop_src = {st_reg.mc[UMS_MC_OUT2], st_reg.mc[UMS_MC_OUT1],
		st_reg.mc[UMS_MC_DTR], st_reg.mc[UMS_MC_RTS]}; // R9 R10 R11 R12
	assign live = st_reg.mc[UMS_MC_LOOP] ? loop_src : ~pin_level;

	// Change detection on the synchronised, substituted levels
	always_comb begin
		delta_set             = live ^ st_reg.prev; // R7 R13
		delta_set[UMS_MS_RI]  = st_reg.prev[UMS_MS_RI] & ~live[UMS_MS_RI]; // R14
	end

	// Status words as read by software
	always_comb begin
		ls_val                    = UMS_LS_TX_IDLE; // R16
		ls_val[UMS_LS_DATA_READY] = head_valid; // R6
		ls_val[UMS_LS_OVERRUN]    = st_reg.overrun;
		ls_val[UMS_LS_PARITY]     = head_valid & head[UMS_CHAR_PE]; // R1 R2
		ms_val = {live, st_reg.delta};
	end

	assign irq_ev = {|delta_set, rx_char_valid & push_ready & rx_char_perr,
		ovr_ev, rx_char_valid & push_ready};

	// Next state of every register
	always_comb begin
		st_next     = st_reg;
		st_next.ack = req;
		st_next.dat = '0;
		if (rd_req) begin
			case (wb_adr_i)
				UMS_OFS_RX_DATA: begin
					st_next.dat[7:0] = head_valid ? head[7:0] : 8'h00;
				end
				UMS_OFS_LINE_STAT: begin
					st_next.dat[7:0] = ls_val;
				end
				UMS_OFS_MODEM_STAT: begin
					st_next.dat[7:0] = ms_val;
				end
				UMS_OFS_MODEM_CTRL: begin
					st_next.dat[7:0] = st_reg.mc;
				end
				UMS_OFS_FIFO_CTRL: begin
					st_next.dat[UMS_FC_ENABLE] = st_reg.fifo_en;
				end
				UMS_OFS_IRQ_STAT: begin
					st_next.dat[UMS_IRQ_N-1:0] = st_reg.irq_stat;
				end
				UMS_OFS_IRQ_ENABLE: begin
					st_next.dat[UMS_IRQ_N-1:0] = st_reg.irq_en;
				end
				default: begin
					st_next.dat = '0; // Unmapped and clear register read zero
				end
			endcase
		end
		// Register writes
		if (wr_req) begin
			case (wb_adr_i)
				UMS_OFS_MODEM_CTRL: begin
					st_next.mc = wb_dat_i[UMS_REG_W-1:0];
				end
				UMS_OFS_FIFO_CTRL: begin
					st_next.fifo_en = wb_dat_i[UMS_FC_ENABLE];
				end
				UMS_OFS_IRQ_ENABLE: begin
					st_next.irq_en = wb_dat_i[UMS_IRQ_N-1:0];
				end
				default: begin
					st_next.mc = st_reg.mc;
				end
			endcase
		end
		// Sticky interrupt bits; an event beats a same-cycle clear
		st_next.irq_stat = st_reg.irq_stat;
		if (wr_req && (wb_adr_i == UMS_OFS_IRQ_CLEAR)) begin
			st_next.irq_stat = st_reg.irq_stat & ~wb_dat_i[UMS_IRQ_N-1:0];
		end
		st_next.irq_stat = st_next.irq_stat | irq_ev;
		st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
		// Overrun holds until line status is read; new overrun wins
		if (rd_ls) begin
			st_next.overrun = 1'b0;
		end
		if (ovr_ev) begin
			st_next.overrun = 1'b1; // R3
		end
		// Shift register always takes the newest character
		if (rx_char_valid) begin
			st_next.shift = rx_char_data; // R4
		end
		// Change bits: a read clears, a change in the same cycle stays
		st_next.delta = (rd_ms ? '0 : st_reg.delta) | delta_set; // R8 R13
		st_next.prev  = live;
		// Reset values; prev keeps tracking the live levels
		if (sys_rst) begin
			st_next.ack      = 1'b0;
			st_next.dat      = '0;
			st_next.mc       = UMS_MC_RESET;
			st_next.fifo_en  = 1'b0;
			st_next.irq_stat = '0;
			st_next.irq_en   = '0;
			st_next.irq      = 1'b0;
			st_next.overrun  = 1'b0; // R16
			st_next.shift    = 8'h00;
			st_next.delta    = '0; // R17
		end
	end

	always_ff @(posedge clock) begin
		st_reg <= st_next;
	end

	assign wb_ack_o     = st_reg.ack;
	assign wb_dat_o     = st_reg.dat;
	assign rx_shift_q   = st_reg.shift;
	assign modem_ctrl_q = st_reg.mc;
	assign modem_irq    = |st_reg.delta; // R15
	assign irq          = st_reg.irq;

	// Checks beside the logic they guard
	a_parity_head: assert property ( // R1
		@(posedge clock) disable iff (sys_rst)
		rx_char_valid && rx_char_perr && level == '0 && !rd_rx
		|=> ls_val[UMS_LS_PARITY] && ls_val[UMS_LS_DATA_READY])
		else $error("parity flag missing for head character");
	a_parity_clean: assert property ( // R2
		@(posedge clock) disable iff (sys_rst)
		!head_valid |-> !ls_val[UMS_LS_PARITY])
		else $error("parity flag with empty queue");
	a_overrun_set: assert property ( // R3
		@(posedge clock) disable iff (sys_rst)
		rx_char_valid && !push_ready |=> ls_val[UMS_LS_OVERRUN])
		else $error("overrun not flagged");
	a_shift_over: assert property ( // R4
		@(posedge clock) disable iff (sys_rst)
		rx_char_valid |=> rx_shift_q == $past(rx_char_data))
		else $error("shift register not overwritten");
	a_overrun_keep: assert property ( // R5
		@(posedge clock) disable iff (sys_rst)
		rx_char_valid && !push_ready && !rd_rx && !flush
		|=> level == $past(level))
		else $error("queue changed on overrun");
	a_ready_level: assert property ( // R6
		@(posedge clock) disable iff (sys_rst)
		ls_val[UMS_LS_DATA_READY] == (level != '0))
		else $error("data ready disagrees with queue level");
	a_ms_clear: assert property ( // R8
		@(posedge clock) disable iff (sys_rst)
		rd_ms && delta_set == '0 |=> ms_val[3:0] == 4'h0)
		else $error("change bits survive status read");
	a_cts_change: assert property ( // R13
		@(posedge clock) disable iff (sys_rst)
		live[UMS_MS_CTS] != st_reg.prev[UMS_MS_CTS]
		|=> st_reg.delta[UMS_MS_CTS])
		else $error("clear to send change missed");
	a_ri_fall_only: assert property ( // R14
		@(posedge clock) disable iff (sys_rst)
		live[UMS_MS_RI] && !st_reg.prev[UMS_MS_RI] &&
		!st_reg.delta[UMS_MS_RI]
		|=> !st_reg.delta[UMS_MS_RI])
		else $error("ring change set on wrong edge");
	a_loop_cd: assert property ( // R9
		@(posedge clock) disable iff (sys_rst)
		st_reg.mc[UMS_MC_LOOP] |-> ms_val[7] == st_reg.mc[UMS_MC_OUT2])
		else $error("loopback carrier bit wrong");
	a_modem_irq: assert property ( // R15
		@(posedge clock) disable iff (sys_rst)
		|delta_set |=> modem_irq)
		else $error("modem interrupt not raised");
	a_reset_status: assert property ( // R16
		@(posedge clock)
		sys_rst |=> ls_val == UMS_LS_RESET && ms_val[3:0] == 4'h0) // R17
		else $error("status not at reset value");

	c_overrun: cover property (@(posedge clock) disable iff (sys_rst)
		ovr_ev);
	c_ms_read: cover property (@(posedge clock) disable iff (sys_rst)
		rd_ms && st_reg.delta != '0);
	c_loopback: cover property (@(posedge clock) disable iff (sys_rst)
		st_reg.mc[UMS_MC_LOOP] && |delta_set);
	c_irq: cover property (@(posedge clock) disable iff (sys_rst)
		irq ##1 !irq);

endmodule : ums_status

// [ums_modem_model.sv]
// Behavioural model of the modem that drives the active-low control pins.
// Assumes the bench requests pin levels on want_n, one bit per signal in
// the order clear to send, set ready, ring, carrier (bits 0 to 3).
module ums_modem_model #(
	parameter int unsigned DELAY = 3
) (
	input  wire logic       clock,
	input  wire logic [3:0] want_n,
	output logic            cts_n,
	output logic            dsr_n,
	output logic            ri_n,
	output logic            cd_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pins lag the request by DELAY cycles, like a slow modem; DELAY >= 2
	logic [DELAY*4-1:0] pipe_reg = '1;

	// Pins idle high so no change is seen straight out of reset
	always @(posedge clock) begin
		pipe_reg <= {pipe_reg[DELAY*4-5:0], want_n};
	end

	// Oldest stage drives the pins
	assign {cd_n, ri_n, dsr_n, cts_n} = pipe_reg[DELAY*4-1 -: 4];

endmodule : ums_modem_model

// [ums_status_tb.sv]
// Self-checking bench of the line and modem status block.
// Assumes the Wishbone slave answers each access with one ack pulse.
module ums_status_tb;
	import ums_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned DEPTH = 4;

	logic                 clock = 1'b0;
	logic                 sys_rst = 1'b1;
	logic                 wb_cyc = 1'b0;
	logic                 wb_stb = 1'b0;
	logic                 wb_we = 1'b0;
	logic [UMS_ADR_W-1:0] wb_adr = '0;
	logic [UMS_SEL_W-1:0] wb_sel = '0;
	logic [UMS_DAT_W-1:0] wb_wdat = '0;
	logic [UMS_DAT_W-1:0] wb_dat_o;
	logic                 wb_ack_o;
	logic                 rx_valid = 1'b0;
	logic [7:0]           rx_data = 8'h00;
	logic                 rx_perr = 1'b0;
	logic [7:0]           rx_shift_q;
	logic [7:0]           modem_ctrl_q;
	logic                 modem_irq;
	logic                 irq;
	logic [3:0]           want_n = 4'hf;
	logic                 cts_n, dsr_n, ri_n, cd_n;
	logic [31:0]          rd;
	logic [31:0]          chg;
	int unsigned          lim;
	int                   errors = 0;
	int                   comparisons = 0;

	// 25 MHz clock
	always #20 clock = ~clock;

	ums_status #(.RX_DEPTH(DEPTH)) u_ums_status (
		.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_char_valid(rx_valid),
		.rx_char_data(rx_data), .rx_char_perr(rx_perr),
		.rx_shift_q(rx_shift_q), .cts_n(cts_n), .dsr_n(dsr_n),
		.ri_n(ri_n), .cd_n(cd_n), .modem_ctrl_q(modem_ctrl_q),
		.modem_irq(modem_irq), .irq(irq)
	);

	ums_modem_model #(.DELAY(3)) u_ums_modem_model (
		.clock(clock), .want_n(want_n), .cts_n(cts_n), .dsr_n(dsr_n),
		.ri_n(ri_n), .cd_n(cd_n)
	);

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One classic cycle; the request holds until ack is sampled high
	task automatic bus(input logic w, input logic [4:0] a,
			input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_sel  <= s;
		wb_wdat <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			errors++;
			conclude();
		end
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask : wr

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp,
			input string what);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		check(what, rd, exp);
	endtask : rd_chk

	// One character out of the shifter, pulse lasts one cycle
	task automatic rx(input logic [7:0] d, input logic p);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_data  <= d;
		rx_perr  <= p;
		@(posedge clock);
		rx_valid <= 1'b0;
	endtask : rx

	task automatic conclude();
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// Watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd_chk(UMS_OFS_LINE_STAT, 32'h0000_0060, "line_status");
		rd_chk(UMS_OFS_MODEM_STAT, 32'h0000_0000, "modem_status");
		check("modem_irq", modem_irq, 1'b0);
		// Holding register first, then the queue; one character too many
		for (int m = 0; m < 2; m++) begin
			lim = (m == 0) ? 1 : DEPTH;
			wr(UMS_OFS_FIFO_CTRL, m);
			for (int k = 0; k <= lim; k++) rx(8'h30 + k, k == 0);
			@(posedge clock);
			check("rx_shift_q", rx_shift_q, 8'h30 + lim);
			rd_chk(UMS_OFS_LINE_STAT, 8'h67, "line_status");
			for (int k = 0; k < lim; k++) begin
				rd_chk(UMS_OFS_RX_DATA, 8'h30 + k, "rx_data");
				chg = (k == lim - 1) ? 8'h60 : 8'h61;
				rd_chk(UMS_OFS_LINE_STAT, chg, "line_status");
			end
			rd_chk(UMS_OFS_RX_DATA, 8'h00, "rx_data");
		end
		// Each pin asserted then released; ring counts only its release
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			want_n[i] <= 1'b0;
			repeat (12) @(posedge clock);
			chg = (i == UMS_MS_RI) ? 0 : (1 << i);
			check("modem_irq", modem_irq, chg != 0);
			rd_chk(UMS_OFS_MODEM_STAT, (1 << (4 + i)) | chg,
				"modem_status");
			rd_chk(UMS_OFS_MODEM_STAT, 1 << (4 + i), "modem_status");
			want_n[i] <= 1'b1;
			repeat (12) @(posedge clock);
			rd_chk(UMS_OFS_MODEM_STAT, 1 << i, "modem_status");
			rd_chk(UMS_OFS_MODEM_STAT, 32'h0000_0000, "modem_status");
			check("modem_irq", modem_irq, 1'b0);
		end
		// Loopback: live bits follow the control outputs
		for (int v = 0; v < 16; v++) begin
			wr(UMS_OFS_MODEM_CTRL, 32'h0000_0010 | v);
			check("modem_ctrl_q", modem_ctrl_q, 32'h0000_0010 | v);
			bus(1'b0, UMS_OFS_MODEM_STAT, 32'h0000_0000, 4'hf);
			check("modem_status", rd & 32'h0000_00f0,
				{24'h00_0000, v[3], v[2], v[0], v[1], 4'h0});
		end
		// Write without the low lane is ignored
		bus(1'b1, UMS_OFS_MODEM_CTRL, 32'h0000_0000, 4'he);
		rd_chk(UMS_OFS_MODEM_CTRL, 8'h1f, "modem_control");
		wr(UMS_OFS_MODEM_CTRL, 32'h0000_0000);
		repeat (12) @(posedge clock);
		// Leaving loopback drops all four live bits, so all change bits set
		rd_chk(UMS_OFS_MODEM_STAT, 32'h0000_000f, "modem_status_live");
		bus(1'b0, UMS_OFS_MODEM_STAT, 32'h0000_0000, 4'hf);
		rd_chk(UMS_OFS_MODEM_STAT, 32'h0000_0000, "modem_status");
		// Unmapped, unaligned and write-only places read zero
		rd_chk(5'h1f, 32'h0000_0000, "unmapped");
		rd_chk(5'h02, 32'h0000_0000, "unaligned");
		rd_chk(UMS_OFS_IRQ_CLEAR, 32'h0000_0000, "irq_clear");
		// Interrupt raised, masked, unmasked and cleared
		wr(UMS_OFS_IRQ_CLEAR, 32'h0000_000f);
		rd_chk(UMS_OFS_IRQ_STAT, 32'h0000_0000, "irq_status");
		wr(UMS_OFS_IRQ_ENABLE, 1 << UMS_IRQ_RX);
		rx(8'h5a, 1'b0);
		repeat (3) @(posedge clock);
		check("irq", irq, 1'b1);
		rd_chk(UMS_OFS_IRQ_STAT, 1 << UMS_IRQ_RX, "irq_status");
		wr(UMS_OFS_IRQ_ENABLE, 32'h0000_0000);
		repeat (2) @(posedge clock);
		check("irq", irq, 1'b0);
		rd_chk(UMS_OFS_IRQ_ENABLE, 32'h0000_0000, "irq_enable");
		wr(UMS_OFS_IRQ_ENABLE, 1 << UMS_IRQ_RX);
		repeat (2) @(posedge clock);
		check("irq", irq, 1'b1);
		wr(UMS_OFS_IRQ_CLEAR, 1 << UMS_IRQ_RX);
		repeat (2) @(posedge clock);
		check("irq", irq, 1'b0);
		rd_chk(UMS_OFS_IRQ_STAT, 32'h0000_0000, "irq_status");
		conclude();
	end

endmodule : ums_status_tb
